/* logic/rst_seq_regs.vh */
/*
 * constants for the reset sequencer: register offsets, reset values,
 * timing counts.
 * assumes a 50 MHz system clock and a core that decodes its own
 * register addresses.
 */
`ifndef RST_SEQ_REGS_VH
`define RST_SEQ_REGS_VH

`define OFS_PORT_A_DATA 8'h12
`define OFS_PORT_A_DIRECTION 8'h13
`define OFS_PORT_B_DATA 8'h14
`define OFS_PORT_B_DIRECTION 8'h15
`define OFS_WATCHDOG_PRESCALE_SELECT 8'h09
`define OFS_STATUS 8'h0A

`define RST_PORT_A 8'hFF
`define RST_PORT_B 3'h7
`define RST_PRESCALE_SELECT 8'h07
`define RST_PC 10'h000

`define STARTUP_CYCLES 1024
`define BROWNOUT_TIME_NS 1000000
`define CLOCK_PERIOD_NS 20
`define BROWNOUT_CYCLES (`BROWNOUT_TIME_NS / `CLOCK_PERIOD_NS)

`endif

/* logic/mcu_reset_sequencer.v */
/*
 * reset sequencer: merges init pin, watchdog expiry and brownout,
 * records the cause, times the start-up delay and holds the reset
 * values of the port and prescale registers.
 * assumes the core reports halt, clear-watchdog and register writes
 * as single-cycle strobes on the system clock.
 */
`timescale 1ns/1ps
`include "rst_seq_regs.vh"

module mcu_reset_sequencer #(
    parameter BROWNOUT_CYCLES = `BROWNOUT_CYCLES
) (
    input wire clock,
    input wire rst,
    input wire external_init_pin_n,
    input wire supply_low,
    input wire brownout_enable,
    input wire watchdog_expired,
    input wire halt_exec,
    input wire watchdog_clear,
    input wire wr_en,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    output reg core_reset,
    output reg pc_reset,
    output reg prescaler_clear,
    output reg halted,
    output reg watchdog_expiry_flag,
    output reg halt_entered_flag,
    output reg [7:0] watchdog_prescale_select,
    output reg [7:0] port_a_data,
    output reg [7:0] port_a_direction,
    output reg [2:0] port_b_data,
    output reg [2:0] port_b_direction
);

// ****************************************
// pin synchroniser
// ****************************************
reg [2:0] pin_sync_r;
reg pin_low_r;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        pin_sync_r <= 3'h7;
        pin_low_r <= 1'b0;
    end else begin
        pin_sync_r <= {pin_sync_r[1:0], external_init_pin_n};
        if (pin_sync_r[2] == pin_sync_r[1])
            pin_low_r <= ~pin_sync_r[2];
    end
end

// ****************************************
// brownout filter
// ****************************************
reg [2:0] low_sync_r;
reg brown_r;
reg [15:0] low_cnt_r;
reg supply_low_s;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        low_sync_r <= 3'h0;
        supply_low_s <= 1'b0;
        low_cnt_r <= 16'h0000;
        brown_r <= 1'b0;
    end else begin
        low_sync_r <= {low_sync_r[1:0], supply_low};
        if (low_sync_r[2] == low_sync_r[1])
            supply_low_s <= low_sync_r[2];
        // glitches of 1ms or less never reach the reset
        // counter saturates at the limit, so a long sag holds
        // the request without wrapping back to zero
        if (!supply_low_s || !brownout_enable) begin
            low_cnt_r <= 16'h0000;
            brown_r <= 1'b0;
        end else if (low_cnt_r == BROWNOUT_CYCLES[15:0]) begin
            brown_r <= 1'b1;
        end else begin
            low_cnt_r <= low_cnt_r + 16'h0001;
        end
    end
end

// ****************************************
// sequencer
// ****************************************
localparam ST_RUN = 2'h0;
localparam ST_HOLD = 2'h1;
localparam ST_START = 2'h2;

reg [1:0] state_r;
reg [10:0] start_cnt_r;
reg cold_r;
wire hard_req;

assign hard_req = pin_low_r | brown_r;

always @(posedge clock or posedge rst) begin
    if (rst) begin
        // power-up: flags cleared, delay applied
        state_r <= ST_START;
        start_cnt_r <= 11'h000;
        cold_r <= 1'b0;
        core_reset <= 1'b1;
        pc_reset <= 1'b1;
        prescaler_clear <= 1'b1;
        halted <= 1'b0;
        watchdog_expiry_flag <= 1'b0;
        halt_entered_flag <= 1'b0;
        watchdog_prescale_select <= `RST_PRESCALE_SELECT;
        port_a_data <= `RST_PORT_A;
        port_a_direction <= `RST_PORT_A;
        port_b_data <= `RST_PORT_B;
        port_b_direction <= `RST_PORT_B;
    end else begin
        pc_reset <= 1'b0;
        prescaler_clear <= 1'b0;
        cold_r <= 1'b0;
        case (state_r)
        ST_RUN: begin
            if (hard_req) begin
                state_r <= ST_HOLD;
                core_reset <= 1'b1;
                cold_r <= 1'b1;
                if (halted) begin
                    // pin wake from halt
                    watchdog_expiry_flag <= 1'b0;
                    halt_entered_flag <= 1'b1;
                end
                if (brown_r)
                    halt_entered_flag <= 1'b0;
                if (brown_r)
                    watchdog_expiry_flag <= 1'b0;
            end else if (watchdog_expired && halted) begin
                // warm reset: pc and stack only, rest kept
                state_r <= ST_START;
                core_reset <= 1'b1;
                pc_reset <= 1'b1;
                start_cnt_r <= 11'h000;
                watchdog_expiry_flag <= 1'b1;
                halt_entered_flag <= 1'b1;
            end else if (watchdog_expired) begin
                state_r <= ST_START;
                core_reset <= 1'b1;
                cold_r <= 1'b1;
                // count restarts from zero for the full start-up wait
                start_cnt_r <= 11'h000;
                watchdog_expiry_flag <= 1'b1;
            end else if (halt_exec) begin
                halted <= 1'b1;
                halt_entered_flag <= 1'b1;
                watchdog_expiry_flag <= 1'b0;
            end else if (watchdog_clear) begin
                watchdog_expiry_flag <= 1'b0;
                halt_entered_flag <= 1'b0;
            end
        end
        ST_HOLD: begin
            cold_r <= 1'b1;
            start_cnt_r <= 11'h000;
            if (!hard_req) begin
                // pin-only running reset releases at once
                if (halted || brown_r) begin
                    state_r <= ST_START;
                end else begin
                    state_r <= ST_RUN;
                    core_reset <= 1'b0;
                end
            end
            if (brown_r)
                halted <= 1'b1;
        end
        ST_START: begin
            if (hard_req) begin
                state_r <= ST_HOLD;
                cold_r <= 1'b1;
            end else if (start_cnt_r == `STARTUP_CYCLES - 1) begin
                state_r <= ST_RUN;
                core_reset <= 1'b0;
                halted <= 1'b0;
            end else begin
                start_cnt_r <= start_cnt_r + 11'h001;
            end
        end
        default: begin
            state_r <= ST_HOLD;
            core_reset <= 1'b1;
        end
        endcase
        if (cold_r) begin
            // cold resets reload; warm reset skips this
            pc_reset <= 1'b1;
            prescaler_clear <= 1'b1;
            watchdog_prescale_select <= `RST_PRESCALE_SELECT;
            port_a_data <= `RST_PORT_A;
            port_a_direction <= `RST_PORT_A;
            port_b_data <= `RST_PORT_B;
            port_b_direction <= `RST_PORT_B;
        end else if (wr_en && !core_reset) begin
            case (wr_addr)
            `OFS_PORT_A_DATA: port_a_data <= wr_data;
            `OFS_PORT_A_DIRECTION: port_a_direction <= wr_data;
            `OFS_PORT_B_DATA: port_b_data <= wr_data[2:0];
            `OFS_PORT_B_DIRECTION: port_b_direction <= wr_data[2:0];
            `OFS_WATCHDOG_PRESCALE_SELECT:
                watchdog_prescale_select <= wr_data;
            default: begin
            end
            endcase
        end
    end
end

// limitation: a brownout seen during start-up re-enters hold but
// keeps the flags, since the cause was already recorded
// memory pointer, accumulator and table registers live in the core
// and get no reset from here, so they keep their value

endmodule

/* bench/rst_seq_sva.sv */
/* port checker for the reset sequencer; assumes the bind at the foot */
`timescale 1ns/1ps
module rst_seq_sva (
    input wire clock, rst, external_init_pin_n, supply_low, halted,
    input wire brownout_enable, watchdog_expired, halt_exec, pc_reset,
    input wire watchdog_clear, core_reset, prescaler_clear,
    input wire watchdog_expiry_flag, halt_entered_flag,
    input wire [7:0] watchdog_prescale_select,
    input wire [2:0] port_b_direction
);
default clocking @(posedge clock); endclocking
default disable iff (rst);
wire run = !core_reset && !halted;
chk_wd_run: assert property (
    watchdog_expired && run |=> core_reset && watchdog_expiry_flag &&
    $stable(halt_entered_flag) ##1 pc_reset && prescaler_clear)
    else $error("watchdog reset");
chk_halt_flags: assert property (
    halt_exec && !watchdog_expired && run |=> halted &&
    halt_entered_flag && !watchdog_expiry_flag) else $error("halt flags");
chk_clear_flags: assert property (
    watchdog_clear && !watchdog_expired && run |=> !halt_entered_flag &&
    !watchdog_expiry_flag) else $error("clear flags");
chk_cold_values: assert property (
    $fell(core_reset) && !(watchdog_expiry_flag && halt_entered_flag) |->
    watchdog_prescale_select == 8'h07 && port_b_direction == 3'h7)
    else $error("cold values");
chk_pin_sync: assert property (
    $fell(external_init_pin_n) && run |=> !core_reset)
    else $error("pin sync");
chk_pin_fast: assert property (
    $rose(external_init_pin_n) && core_reset && !halt_entered_flag &&
    !supply_low |-> ##[1:8] !core_reset) else $error("pin release");
chk_bo_filter: assert property (
    $rose(supply_low) && !core_reset && external_init_pin_n |=>
    !core_reset [*8]) else $error("brownout filter");
chk_bo_off: assert property (
    (!brownout_enable && external_init_pin_n && !watchdog_expired &&
    !core_reset) [*5] |=> !core_reset) else $error("brownout off");
endmodule
bind mcu_reset_sequencer rst_seq_sva u_chk (.*);

/* bench/reset_env.sv */
/* init pin and supply monitor; assumes the bench calls hold */
`timescale 1ns/1ps
module reset_env (
    input wire clock,
    output logic external_init_pin_n = 1'b1,
    output logic supply_low = 1'b0
);
// sel high sags the supply, low pulls the pin, for n cycles
task automatic hold(input logic sel, input int n);
    @(negedge clock);
    if (sel) supply_low = 1'b1;
    else external_init_pin_n = 1'b0;
    repeat (n) @(negedge clock);
    supply_low = 1'b0;
    external_init_pin_n = 1'b1;
endtask
endmodule

/* bench/tb.sv */
/* bench for the reset sequencer; assumes reset_env as far side */
`timescale 1ns/1ps
module tb;
logic clock = 1'b0, rst = 1'b1, wr_en = 1'b0, watchdog_clear = 1'b0;
logic brownout_enable = 1'b1;
logic watchdog_expired = 1'b0, halt_exec = 1'b0;
logic [7:0] wr_addr = 8'h09, wr_data = 8'h00;
logic external_init_pin_n, supply_low, core_reset, pc_reset, halted;
logic prescaler_clear, watchdog_expiry_flag, halt_entered_flag;
logic [7:0] watchdog_prescale_select, port_a_data, port_a_direction;
logic [2:0] port_b_data, port_b_direction;
int fails = 0, tests_run = 0, n;
always #10 clock = ~clock;
reset_env u_env (.clock, .external_init_pin_n, .supply_low);
mcu_reset_sequencer #(.BROWNOUT_CYCLES(20)) u_dut (.*);
task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
task automatic check(input string s, input logic [29:0] e, g);
    tests_run++;
    if (g !== e) fails++;
    if (g !== e) $display("Error %s expected %h seen %h", s, e, g);
endtask
task automatic wait_rel; // n counts cycles until release
    for (n = 0; core_reset !== 1'b0; n++) begin
        @(negedge clock);
        if (n > 3000) fails++;
        if (n > 3000) complete_run;
    end
endtask
task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
endtask
task automatic dirty; // zeros, so a reload is visible
    for (int i = 0; i < 6; i++) begin
        @(negedge clock);
        wr_en = i < 5;
        wr_addr = (i > 0) ? 8'h11 + i[7:0] : 8'h09;
    end
endtask
task automatic state(input logic [1:0] f, input logic c);
    check("flags", f, {watchdog_expiry_flag, halt_entered_flag});
    check("regs", c ? 30'h1FFFFFF : 30'h0000000, {watchdog_prescale_select,
        port_a_data, port_a_direction, port_b_data, port_b_direction});
endtask
task automatic t_run;
    dirty;
    pulse(watchdog_expired);
    wait_rel;
    check("wd_delay", 1'b1, n > 1018 && n < 1030);
    state(2'b10, 1'b1);
    dirty;
    u_env.hold(1'b0, 10);
    wait_rel;
    check("pin_delay", 1'b1, n < 16);
    state(2'b10, 1'b1);
endtask
task automatic t_halt; // warm wake keeps registers
    dirty;
    pulse(halt_exec);
    pulse(watchdog_expired);
    @(negedge clock);
    wait_rel;
    state(2'b11, 1'b0);
    pulse(watchdog_clear);
    pulse(halt_exec);
    u_env.hold(1'b0, 10);
    wait_rel;
    check("wake_delay", 1'b1, n > 1000);
    state(2'b01, 1'b1);
endtask
task automatic t_brown;
    dirty;
    brownout_enable = 1'b0;
    u_env.hold(1'b1, 40);
    check("bo_off", 1'b0, core_reset);
    brownout_enable = 1'b1;
    u_env.hold(1'b1, 15);
    repeat (8) @(negedge clock);
    check("bo_short", 1'b0, core_reset);
    u_env.hold(1'b1, 40);
    wait_rel;
    check("bo_delay", 1'b1, n > 1000);
    state(2'b00, 1'b1);
endtask
initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    wait_rel;
    check("startup", 1'b1, n > 1020 && n < 1030);
    state(2'b00, 1'b1);
    t_run;
    t_halt;
    t_brown;
    complete_run;
end
endmodule
